// ### tb/ccu_capcom_checker.sv
`timescale 1ns/1ps
module ccu_capcom_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [ccu_pkg::NUM_CH-1:0] cc_pin_o,
   input wire logic [ccu_pkg::NUM_CH-1:0] cc_pin_oe_o,
   input wire logic [ccu_pkg::NUM_CH-1:0] irq_o
);
   ////////////////////////////////////////////////////////////////////////
   // bus handshake: one ack per taken request, exactly one cycle later
   chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack stood longer than one cycle");
   chk_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");
   chk_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   chk_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> wb_dat_o == '0) else $error("read data not zero outside ack");
   // reset clears every output whether ce is low or high; the check samples reset with ce high only
   chk_reset_quiet: assert property (@(posedge clk_i) (rst_i && ce_i) |=>
      (irq_o == '0 && cc_pin_oe_o == '0 && cc_pin_o == '0 && !wb_ack_o))
      else $error("outputs not cleared by reset");
   // sticky flags fall only by reset or a taken write to the flag register
   chk_irq_clear_cause: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(~irq_o & $past(irq_o))) |-> $past(rst_i) || $past(wb_cyc_i && wb_stb_i
      && wb_we_i && !wb_ack_o && wb_adr_i[7:2] == ccu_pkg::ADR_IRQ[7:2]))
      else $error("flag dropped without a clearing write");
   // an undriven pin must not show a changing drive level
   chk_pin_needs_oe: assert property (@(posedge clk_i) disable iff (rst_i)
      ((cc_pin_o ^ $past(cc_pin_o)) & ~(cc_pin_oe_o | $past(cc_pin_oe_o))) == '0)
      else $error("pin level moved while undriven");
   // drive enables follow the mode registers only
   chk_oe_after_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (cc_pin_oe_o != $past(cc_pin_oe_o)) |-> $past(wb_ack_o && wb_we_i) || $past(rst_i))
      else $error("enable changed without a mode write");
endmodule
bind ccu_capcom ccu_capcom_checker i_ccu_capcom_checker (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cc_pin_o(cc_pin_o),
   .cc_pin_oe_o(cc_pin_oe_o), .irq_o(irq_o));

// ### tb/ccu_pin_model.sv
`timescale 1ns/1ps
// far side of the channel pins: an outside source drives each pin unless
// the channel drives it, so the resolved wire feeds back into the unit
module ccu_pin_model (
   input wire logic [ccu_pkg::NUM_CH-1:0] ext_lvl_i,
   input wire logic [ccu_pkg::NUM_CH-1:0] pin_drv_i,
   input wire logic [ccu_pkg::NUM_CH-1:0] pin_oe_i,
   output logic [ccu_pkg::NUM_CH-1:0] pin_lvl_o
);
   ////////////////////////////////////////////////////////////////////////
   // resolved level; the outside source yields while the channel drives
   assign pin_lvl_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & ext_lvl_i);
endmodule

// ### tb/tb_ccu_capcom.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb_ccu_capcom;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m;} ccu_note_type;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, wb_dat_o, seed = 32'h9480, r1, r2;
   logic wb_ack_o, ext = 1'b0, gp6 = 1'b0;
   logic [15:0] pin_lvl = 16'h0, cc_pin_i, cc_pin_o, cc_pin_oe_o, irq_o, prev;
   int compares = 0, n_mismatch = 0, cyc_cnt = 0, tog[16];
   ccu_note_type q[$];
   ccu_note_type note;
   ccu_capcom i_ccu_capcom (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cc_pin_i(cc_pin_i), .cc_pin_o(cc_pin_o),
      .cc_pin_oe_o(cc_pin_oe_o), .ext_count_i(ext), .gp6_ovf_i(gp6), .irq_o(irq_o));
   ccu_pin_model i_ccu_pin_model (.ext_lvl_i(pin_lvl), .pin_drv_i(cc_pin_o),
      .pin_oe_i(cc_pin_oe_o), .pin_lvl_o(cc_pin_i));
   ////////////////////////////////////////////////////////////////////////
   // clock, timeout and pin toggle counting
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc_cnt++;
      for (int i = 0; i < 16; i++) begin
         if (!rst_i && cc_pin_o[i] != prev[i]) tog[i]++;
      end
      prev = cc_pin_o;
      if (cyc_cnt == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   // read results checked against the oldest note when ack appears
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && we === 1'b0 && q.size() > 0) begin
         note = q.pop_front();
         `CHK(note.nm, note.e, wb_dat_o & note.m)
      end
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // classic cycle; the master never assumes a latency, it waits for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk_i);
      // only the bench timeout ends a wait that never sees ack
      while (wb_ack_o !== 1'b1) begin
         @(posedge clk_i);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m);
      q.push_back('{nm, e, m});
      wb(1'b0, a, 32'h0);
   endtask
   // value first, then mode, so the mode write also rearms the channel
   task automatic cfg(input int i, input logic [7:0] md, input logic [15:0] v);
      wb(1'b1, ccu_pkg::ADR_CHVAL + 8'(4 * i), {16'h0000, v});
      wb(1'b1, ccu_pkg::ADR_CHMODE + 8'(4 * i), {24'h000000, md});
   endtask
   // external count edge held long enough to pass the input synchronizer
   task automatic tick();
      ext <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
   task automatic end_sim();
      $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd("tctrl", ccu_pkg::ADR_TCTRL, 32'h0, 32'hFFFF_FFFF);
      rd("unmapped", 8'h3C, 32'h0, 32'hFFFF_FFFF);
      rd("chval0", ccu_pkg::ADR_CHVAL, 32'h0, 32'hFFFF_FFFF);
      $display("test reset done");
      // timer0 on overflow pulses of timer six, wrapping through reload
      wb(1'b1, ccu_pkg::ADR_TREL0, 32'hFFF0);
      wb(1'b1, ccu_pkg::ADR_TCNT0, 32'hFFFE);
      wb(1'b1, ccu_pkg::ADR_TCTRL, 32'h000C);
      repeat (3) begin
         gp6 <= 1'b1;
         @(posedge clk_i);
         gp6 <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
      rd("cnt0", ccu_pkg::ADR_TCNT0, 32'hFFF1, 32'hFFFF);
      // two 64-edge windows: staggered base tick gives 8, divide by four gives 16
      wb(1'b1, ccu_pkg::ADR_TCNT0, 32'h0);
      wb(1'b1, ccu_pkg::ADR_TCTRL, 32'h0001_0008);
      repeat (61) @(posedge clk_i);
      wb(1'b1, ccu_pkg::ADR_TCTRL, 32'h0009);
      repeat (61) @(posedge clk_i);
      wb(1'b1, ccu_pkg::ADR_TCTRL, 32'h0);
      rd("cnt_pre", ccu_pkg::ADR_TCNT0, 32'h0018, 32'hFFFF);
      $display("test timebase done");
      // capture on rising, falling and both edges with the timer held still
      r1 = nxt() & 32'hFFFF;
      wb(1'b1, ccu_pkg::ADR_TCNT0, r1);
      cfg(8, 8'h09, 16'h0);
      cfg(9, 8'h11, 16'h0);
      cfg(10, 8'h19, 16'h0);
      pin_lvl <= 16'h0700;
      repeat (8) @(posedge clk_i);
      rd("stat", ccu_pkg::ADR_STAT, 32'h0700, 32'hFFFF);
      rd("irq_rise", ccu_pkg::ADR_IRQ, 32'h0500, 32'h0700);
      rd("cap8", ccu_pkg::ADR_CHVAL + 8'd32, r1, 32'hFFFF);
      rd("cap9", ccu_pkg::ADR_CHVAL + 8'd36, 32'h0, 32'hFFFF);
      wb(1'b1, ccu_pkg::ADR_IRQ, 32'hFFFF);
      r2 = nxt() & 32'hFFFF;
      wb(1'b1, ccu_pkg::ADR_TCNT0, r2);
      pin_lvl <= 16'h0000;
      repeat (8) @(posedge clk_i);
      rd("irq_fall", ccu_pkg::ADR_IRQ, 32'h0600, 32'h0700);
      rd("cap9b", ccu_pkg::ADR_CHVAL + 8'd36, r2, 32'hFFFF);
      rd("cap10", ccu_pkg::ADR_CHVAL + 8'd40, r2, 32'hFFFF);
      rd("cap8b", ccu_pkg::ADR_CHVAL + 8'd32, r1, 32'hFFFF);
      $display("test capture done");
      // compare modes on timer1 counting external edges, period of four counts
      wb(1'b1, ccu_pkg::ADR_IRQ, 32'hFFFF);
      wb(1'b1, 8'h10, 32'hFFFC);
      wb(1'b1, 8'h0C, 32'hFFFC);
      cfg(0, 8'h23, 16'hFFFD);
      cfg(1, 8'h22, 16'hFFFD);
      cfg(2, 8'h24, 16'hFFFD);
      cfg(3, 8'h25, 16'hFFFE);
      cfg(4, 8'h63, 16'hFFFD);
      cfg(5, 8'h26, 16'hFFFD);
      cfg(13, 8'h26, 16'hFFFE);
      tog = '{default: 0};
      wb(1'b1, ccu_pkg::ADR_TCTRL, 32'h0D00);
      tick();
      rd("irq_m1", ccu_pkg::ADR_IRQ, 32'h0037, 32'h203F);
      `CHK("oe", 16'h0039, cc_pin_oe_o)
      `CHK("tog0", 1, tog[0])
      wb(1'b1, ccu_pkg::ADR_IRQ, 32'hFFFF);
      wb(1'b1, 8'h0C, 32'hFFFC);
      tick();
      rd("irq_m2", ccu_pkg::ADR_IRQ, 32'h0023, 32'h203F);
      `CHK("tog0b", 2, tog[0])
      `CHK("tog4", 1, tog[4])
      wb(1'b1, ccu_pkg::ADR_IRQ, 32'hFFFF);
      tick();
      `CHK("pin3_set", 1'b1, cc_pin_o[3])
      `CHK("tog5", 3, tog[5])
      `CHK("irq_o", 16'h2008, irq_o & 16'h203F)
      wb(1'b1, ccu_pkg::ADR_IRQ, 32'hFFFF);
      tick();
      tick();
      `CHK("pin3_clr", 1'b0, cc_pin_o[3])
      tick();
      rd("irq_m3", ccu_pkg::ADR_IRQ, 32'h0004, 32'h0004);
      `CHK("tog0c", 3, tog[0])
      `CHK("tog4b", 1, tog[4])
      `CHK("tog5b", 4, tog[5])
      $display("test compare done");
      end_sim();
   end
endmodule

// ### verilog/ccu_capcom.sv
`timescale 1ns/1ps
// Contract
// R1 - sixteen channels; one-cycle resolution, eight cycles when staggered operation selected
// R2 - two independent 16-bit time-base timers, each with its own reload register
// R3 - timer clock: prescaled system clock or overflow pulses of external timer six
// R4 - an external count input can advance a timer for event-relative scheduling
// R5 - sixteen channel registers, each assignable to either timer, capture or compare
// R6 - each channel owns one pin: capture trigger input, compare event output
// R7 - capture copies the assigned timer count into the channel register on qualifying edge
// R8 - each capture raises that channel's own interrupt request
// R9 - capture edge per channel: rising, falling, or both
// R10 - compare channels match against assigned timer on every count, then act per mode
// R11 - compare mode 0: interrupt only, pin untouched, several per period
// R12 - compare mode 1: pin toggles on every match, several per period
// R13 - compare mode 2: interrupt only, at most one per timer period
// R14 - compare mode 3: match drives pin high, timer overflow low, one per period
// R15 - paired mode: two registers toggle one shared pin, several events per period
// R16 - one-shot option with any compare mode gives a single edge or pulse
// R17 - on overflow a timer loads its reload register and counts on from it
// R18 - every compare event sets that channel's interrupt request flag
module ccu_capcom (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [ccu_pkg::NUM_CH-1:0] cc_pin_i,
   output logic [ccu_pkg::NUM_CH-1:0] cc_pin_o,
   output logic [ccu_pkg::NUM_CH-1:0] cc_pin_oe_o,
   input wire logic ext_count_i,
   input wire logic gp6_ovf_i,
   output logic [ccu_pkg::NUM_CH-1:0] irq_o
);
   localparam int N = ccu_pkg::NUM_CH;
   localparam int TW = ccu_pkg::TIMER_W;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // byte-lane merge of a bus write into an existing word
   function automatic logic [31:0] ccu_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // word address equality, low two address bits ignored
   function automatic logic ccu_word(input logic [7:0] adr, input logic [7:0] base);
      return adr[7:2] == base[7:2];
   endfunction

   // channel pages are 64 bytes; the top two address bits select the page
   function automatic logic ccu_in_page(input logic [7:0] adr, input logic [7:0] base);
      return adr[7:6] == base[7:6];
   endfunction

   // prescaled tick: divide by four to the power of the select value
   function automatic logic ccu_pre_tick(input logic [1:0] sel,
                                         input logic [ccu_pkg::PRE_W-1:0] pre);
      logic [ccu_pkg::PRE_W-1:0] mask;
      mask = '0;
      for (int k = 0; k < ccu_pkg::PRE_W; k++) begin
         if (k < 2 * int'(sel)) begin
            mask[k] = 1'b1;
         end
      end
      return (pre & mask) == mask;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus, control, prescaler and input synchronisers

   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic [31:0] tctrl_reg, tctrl_next;
   logic [ccu_pkg::PRE_W-1:0] pre_reg, pre_next;
   logic [ccu_pkg::STG_W-1:0] stg_reg, stg_next;
   logic [N-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
   logic [N-1:0] pin_s1_next, pin_s2_next, pin_s3_next;
   logic [2:0] ext_sh_reg, ext_sh_next;

   logic bus_req, wr_stb, base_tick, ext_rise;
   logic [N-1:0] irq_clr, flags, dbl_hit, dbl_sel;
   logic [31:0] rd;
   logic [TW-1:0] tcnt [ccu_pkg::NUM_TIMERS];
   logic [TW-1:0] trel [ccu_pkg::NUM_TIMERS];
   logic [ccu_pkg::NUM_TIMERS-1:0] tupd, tovf;
   logic [ccu_pkg::CHMODE_W-1:0] ch_mode [N];
   logic [TW-1:0] ch_val [N];

   // a request is taken once; ack follows one cycle later and drops the cycle after
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_stb = bus_req & wb_we_i;

   // staggered operation slows the base tick to one in eight cycles
   assign base_tick = ~tctrl_reg[ccu_pkg::TCTRL_STAGGER_BIT] | (&stg_reg); // R1
   assign ext_rise = ext_sh_reg[1] & ~ext_sh_reg[2]; // R4

   // write-one-to-clear for the request flags, honouring byte lanes
   assign irq_clr = (wr_stb && ccu_word(wb_adr_i, ccu_pkg::ADR_IRQ)) ?
                    (wb_dat_i[N-1:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}) : '0;

   // read mux; unmapped addresses read zero
   always_comb begin
      rd = 32'h0000_0000;
      if (ccu_word(wb_adr_i, ccu_pkg::ADR_TCTRL)) begin
         rd = tctrl_reg;
      end else if (ccu_word(wb_adr_i, ccu_pkg::ADR_IRQ)) begin
         rd = {16'h0000, flags};
      end else if (ccu_word(wb_adr_i, ccu_pkg::ADR_STAT)) begin
         rd = {16'h0000, pin_s2_reg};
      end else if (ccu_in_page(wb_adr_i, ccu_pkg::ADR_CHMODE)) begin
         rd = {25'h0000000, ch_mode[wb_adr_i[5:2]]};
      end else if (ccu_in_page(wb_adr_i, ccu_pkg::ADR_CHVAL)) begin
         rd = {16'h0000, ch_val[wb_adr_i[5:2]]};
      end else begin
         for (int t = 0; t < ccu_pkg::NUM_TIMERS; t++) begin
            if (ccu_word(wb_adr_i, ccu_pkg::ADR_TCNT0 + 8'(t * 8))) begin
               rd = {16'h0000, tcnt[t]};
            end
            if (ccu_word(wb_adr_i, ccu_pkg::ADR_TREL0 + 8'(t * 8))) begin
               rd = {16'h0000, trel[t]};
            end
         end
      end
   end

   // next values of the global group
   always_comb begin
      ack_next = bus_req;
      rdat_next = bus_req ? rd : 32'h0000_0000;
      tctrl_next = tctrl_reg;
      if (wr_stb && ccu_word(wb_adr_i, ccu_pkg::ADR_TCTRL)) begin
         tctrl_next = ccu_merge(tctrl_reg, wb_dat_i, wb_sel_i) & ccu_pkg::TCTRL_MASK;
      end
      stg_next = stg_reg + 3'h1;
      pre_next = base_tick ? pre_reg + 6'h01 : pre_reg;
      // first stage feeds only the second; edges are taken from the later stages
      pin_s1_next = cc_pin_i;
      pin_s2_next = pin_s1_reg;
      pin_s3_next = pin_s2_reg;
      ext_sh_next = {ext_sh_reg[1:0], ext_count_i};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
         tctrl_reg <= ccu_pkg::TCTRL_RESET;
         pre_reg <= '0;
         stg_reg <= '0;
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
         ext_sh_reg <= 3'h0;
      end else if (ce_i) begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
         tctrl_reg <= tctrl_next;
         pre_reg <= pre_next;
         stg_reg <= stg_next;
         pin_s1_reg <= pin_s1_next;
         pin_s2_reg <= pin_s2_next;
         pin_s3_reg <= pin_s3_next;
         ext_sh_reg <= ext_sh_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // time-base timers

   for (genvar t = 0; t < ccu_pkg::NUM_TIMERS; t++) begin : g_timer
      localparam logic [7:0] CNT_ADR = ccu_pkg::ADR_TCNT0 + 8'(t * 8);
      localparam logic [7:0] REL_ADR = ccu_pkg::ADR_TREL0 + 8'(t * 8);
      ccu_tb_if tif();
      ccu_pkg::ccu_clksel_type sel;
      logic [31:0] m_cnt, m_rel;

      assign sel = ccu_pkg::ccu_clksel_type'(tctrl_reg[t*ccu_pkg::TCTRL_STRIDE +: 3]);
      assign m_cnt = ccu_merge({16'h0000, tif.cnt}, wb_dat_i, wb_sel_i);
      assign m_rel = ccu_merge({16'h0000, tif.rel}, wb_dat_i, wb_sel_i);

      // clock source selection
      always_comb begin
         case (sel)
            ccu_pkg::CLK_DIV1, ccu_pkg::CLK_DIV4, ccu_pkg::CLK_DIV16,
            ccu_pkg::CLK_DIV64: begin
               tif.tick = base_tick & ccu_pre_tick(sel[1:0], pre_reg); // R3
            end
            ccu_pkg::CLK_GP6: begin
               tif.tick = gp6_ovf_i; // R3
            end
            ccu_pkg::CLK_EXT: begin
               tif.tick = ext_rise; // R4
            end
            default: begin
               tif.tick = 1'b0;
            end
         endcase
      end

      assign tif.run = tctrl_reg[t*ccu_pkg::TCTRL_STRIDE + ccu_pkg::TCTRL_RUN_BIT];
      assign tif.wr_cnt = wr_stb & ccu_word(wb_adr_i, CNT_ADR);
      assign tif.wr_rel = wr_stb & ccu_word(wb_adr_i, REL_ADR);
      assign tif.wdata = tif.wr_cnt ? m_cnt[TW-1:0] : m_rel[TW-1:0];

      ccu_timebase u_tb (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ce_i(ce_i),
         .tb(tif.timer)
      );

      assign tcnt[t] = tif.cnt;
      assign trel[t] = tif.rel;
      assign tupd[t] = tif.upd;
      assign tovf[t] = tif.ovf;
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel array

   for (genvar i = 0; i < N; i++) begin : g_ch
      logic [TW-1:0] val_reg, val_next;
      logic [ccu_pkg::CHMODE_W-1:0] mode_reg, mode_next;
      logic flag_reg, flag_next, pin_reg, pin_next, oe_reg, oe_next;
      logic armed_reg, armed_next, done_reg, done_next;
      ccu_pkg::ccu_mode_type md;
      logic tsel, hit, rise, fall, cap_ev, ev, wr_m, wr_v, pair_tog, pair_own;
      logic [31:0] m_mode, m_val;

      assign md = ccu_pkg::ccu_mode_type'(mode_reg[ccu_pkg::CH_MODE_LSB +: 3]);
      assign tsel = mode_reg[ccu_pkg::CH_TSEL_BIT]; // R5
      // compare is evaluated only when the assigned timer has just counted
      assign hit = tupd[tsel] && (tcnt[tsel] == val_reg) && !done_reg; // R10
      assign rise = pin_s2_reg[i] & ~pin_s3_reg[i];
      assign fall = ~pin_s2_reg[i] & pin_s3_reg[i];
      assign cap_ev = (md == ccu_pkg::MODE_CAP) && !done_reg &&
                      ((rise && mode_reg[ccu_pkg::CH_RISE_BIT]) ||
                       (fall && mode_reg[ccu_pkg::CH_FALL_BIT])); // R9
      assign wr_m = wr_stb && ccu_in_page(wb_adr_i, ccu_pkg::ADR_CHMODE) &&
                    (wb_adr_i[5:2] == 4'(i));
      assign wr_v = wr_stb && ccu_in_page(wb_adr_i, ccu_pkg::ADR_CHVAL) &&
                    (wb_adr_i[5:2] == 4'(i));
      assign m_mode = ccu_merge({25'h0000000, mode_reg}, wb_dat_i, wb_sel_i);
      assign m_val = ccu_merge({16'h0000, val_reg}, wb_dat_i, wb_sel_i);

      // event qualification per mode
      always_comb begin
         case (md)
            ccu_pkg::MODE_CAP: begin
               ev = cap_ev;
            end
            ccu_pkg::MODE_CMP0, ccu_pkg::MODE_CMP1, ccu_pkg::MODE_DBL: begin
               ev = hit; // R11 R12 R15
            end
            ccu_pkg::MODE_CMP2, ccu_pkg::MODE_CMP3: begin
               ev = hit & armed_reg; // R13 R14
            end
            default: begin
               ev = 1'b0;
            end
         endcase
      end

      assign dbl_hit[i] = ev && (md == ccu_pkg::MODE_DBL);
      assign dbl_sel[i] = (md == ccu_pkg::MODE_DBL);

      // lower half pins are shared by channel i and i+N/2 in paired mode
      if (i < N / 2) begin : g_pair
         assign pair_tog = dbl_hit[i] | dbl_hit[i + N/2]; // R15
         assign pair_own = dbl_sel[i] | dbl_sel[i + N/2];
      end else begin : g_nopair
         assign pair_tog = 1'b0;
         assign pair_own = 1'b0;
      end

      // channel next state; flag sets and captures win over bus writes, a mode write wins over done and armed
      always_comb begin
         val_next = val_reg;
         mode_next = mode_reg;
         flag_next = flag_reg;
         pin_next = pin_reg;
         armed_next = armed_reg;
         done_next = done_reg;
         if (wr_v) begin
            val_next = m_val[TW-1:0];
         end
         if (cap_ev) begin
            val_next = tcnt[tsel]; // R7
         end
         if (irq_clr[i]) begin
            flag_next = 1'b0;
         end
         if (ev) begin
            flag_next = 1'b1; // R8 R18
            if (mode_reg[ccu_pkg::CH_ONESHOT_BIT]) begin
               done_next = 1'b1; // R16
            end
         end
         // once-per-period modes re-arm on the assigned timer's overflow
         if (md == ccu_pkg::MODE_CMP2 || md == ccu_pkg::MODE_CMP3) begin
            if (ev) begin
               armed_next = 1'b0; // R13 R14
            end else if (tovf[tsel]) begin
               armed_next = 1'b1;
            end
         end
         if (md == ccu_pkg::MODE_CMP3) begin
            if (ev) begin
               pin_next = 1'b1; // R14
            end else if (tovf[tsel]) begin
               pin_next = 1'b0; // R14
            end
         end else if ((md == ccu_pkg::MODE_CMP1 && ev) || pair_tog) begin
            pin_next = ~pin_reg; // R12 R15
         end
         // rewriting the mode restarts a one-shot channel and arms it
         if (wr_m) begin
            mode_next = m_mode[ccu_pkg::CHMODE_W-1:0]; // R5
            done_next = 1'b0;
            armed_next = 1'b1;
         end
         oe_next = (md == ccu_pkg::MODE_CMP1) || (md == ccu_pkg::MODE_CMP3) || pair_own; // R6
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            val_reg <= ccu_pkg::CHVAL_RESET;
            mode_reg <= ccu_pkg::CHMODE_RESET;
            flag_reg <= 1'b0;
            pin_reg <= 1'b0;
            oe_reg <= 1'b0;
            armed_reg <= 1'b1;
            done_reg <= 1'b0;
         end else if (ce_i) begin
            val_reg <= val_next;
            mode_reg <= mode_next;
            flag_reg <= flag_next;
            pin_reg <= pin_next;
            oe_reg <= oe_next;
            armed_reg <= armed_next;
            done_reg <= done_next;
         end
      end

      assign ch_mode[i] = mode_reg;
      assign ch_val[i] = val_reg;
      assign flags[i] = flag_reg;
      assign irq_o[i] = flag_reg;
      assign cc_pin_o[i] = pin_reg;
      assign cc_pin_oe_o[i] = oe_reg;
   end
endmodule

// ### verilog/ccu_pkg.sv
package ccu_pkg;
   // array and counter sizes
   localparam int NUM_CH = 16;
   localparam int TIMER_W = 16;
   localparam int NUM_TIMERS = 2;
   localparam int PRE_W = 6;
   localparam int STG_W = 3;
   localparam int CHMODE_W = 7;

   // register byte offsets
   localparam logic [7:0] ADR_TCTRL = 8'h00;
   localparam logic [7:0] ADR_TCNT0 = 8'h04;
   localparam logic [7:0] ADR_TREL0 = 8'h08;
   localparam logic [7:0] ADR_TSTRIDE = 8'h08;
   localparam logic [7:0] ADR_IRQ = 8'h14;
   localparam logic [7:0] ADR_STAT = 8'h18;
   localparam logic [7:0] ADR_CHMODE = 8'h40;
   localparam logic [7:0] ADR_CHVAL = 8'h80;

   // timer control fields, timer t uses bits t*TCTRL_STRIDE upward
   localparam int TCTRL_STRIDE = 8;
   localparam int TCTRL_SEL_W = 3;
   localparam int TCTRL_RUN_BIT = 3;
   localparam int TCTRL_STAGGER_BIT = 16;
   localparam logic [31:0] TCTRL_MASK = 32'h0001_0F0F;
   localparam logic [31:0] TCTRL_RESET = 32'h0000_0000;

   // channel mode fields
   localparam int CH_MODE_LSB = 0;
   localparam int CH_RISE_BIT = 3;
   localparam int CH_FALL_BIT = 4;
   localparam int CH_TSEL_BIT = 5;
   localparam int CH_ONESHOT_BIT = 6;
   localparam logic [CHMODE_W-1:0] CHMODE_RESET = 7'h00;
   localparam logic [TIMER_W-1:0] CHVAL_RESET = 16'h0000;
   localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;

   // timer clock sources
   typedef enum logic [TCTRL_SEL_W-1:0] {
      CLK_DIV1, CLK_DIV4, CLK_DIV16, CLK_DIV64, CLK_GP6, CLK_EXT
   } ccu_clksel_type;

   // channel operating modes
   typedef enum logic [2:0] {
      MODE_OFF, MODE_CAP, MODE_CMP0, MODE_CMP1, MODE_CMP2, MODE_CMP3, MODE_DBL
   } ccu_mode_type;
endpackage

// ### verilog/ccu_tb_if.sv
`timescale 1ns/1ps
interface ccu_tb_if;
   logic tick;
   logic run;
   logic wr_cnt;
   logic wr_rel;
   logic [ccu_pkg::TIMER_W-1:0] wdata;
   logic [ccu_pkg::TIMER_W-1:0] cnt;
   logic [ccu_pkg::TIMER_W-1:0] rel;
   logic upd;
   logic ovf;

   modport timer (input tick, run, wr_cnt, wr_rel, wdata, output cnt, rel, upd, ovf);
   modport user (output tick, run, wr_cnt, wr_rel, wdata, input cnt, rel, upd, ovf);
endinterface

// ### verilog/ccu_timebase.sv
`timescale 1ns/1ps
module ccu_timebase (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   ccu_tb_if.timer tb
);
   logic [ccu_pkg::TIMER_W-1:0] cnt_reg, cnt_next;
   logic [ccu_pkg::TIMER_W-1:0] rel_reg, rel_next;
   logic upd_reg, upd_next;
   logic ovf_reg, ovf_next;

   ////////////////////////////////////////////////////////////////////////////
   // count up on each tick, reload on wrap; a bus write to the count wins
   always_comb begin
      cnt_next = cnt_reg;
      rel_next = rel_reg;
      upd_next = 1'b0;
      ovf_next = 1'b0;
      if (tb.wr_rel) begin
         rel_next = tb.wdata; // R2
      end
      if (tb.wr_cnt) begin
         cnt_next = tb.wdata;
      end else if (tb.run && tb.tick) begin
         upd_next = 1'b1;
         if (cnt_reg == {ccu_pkg::TIMER_W{1'b1}}) begin
            cnt_next = rel_reg; // R17
            ovf_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 16'h0001; // R2
         end
      end
   end

   // upd and ovf are registered with the count so users see the new value with them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= ccu_pkg::TIMER_RESET;
         rel_reg <= ccu_pkg::TIMER_RESET;
         upd_reg <= 1'b0;
         ovf_reg <= 1'b0;
      end else if (ce_i) begin
         cnt_reg <= cnt_next;
         rel_reg <= rel_next;
         upd_reg <= upd_next;
         ovf_reg <= ovf_next;
      end
   end

   assign tb.cnt = cnt_reg;
   assign tb.rel = rel_reg;
   assign tb.upd = upd_reg;
   assign tb.ovf = ovf_reg;
endmodule
